/* File: dbc_params.svh */
// register select codes, command bit positions and reset values
`ifndef DBC_PARAMS_SVH
`define DBC_PARAMS_SVH
`define DBC_RS_CNT_A 5'h04
`define DBC_RS_CNT_B 5'h05
`define DBC_RS_BASE_A 5'h07
`define DBC_RS_BASE_B 5'h08
`define DBC_RS_MASK_A 5'h09
`define DBC_RS_MASK_B 5'h0a
`define DBC_RS_CPUSCR 5'h0b
`define DBC_RS_NONE 5'h0c
`define DBC_RS_CTRL 5'h0d
`define DBC_RS_STAT 5'h0e
`define DBC_CMD_RW 7
`define DBC_CMD_GO 6
`define DBC_CMD_EX 5
`define DBC_CTL_RESET 32'h0000_0000
`define DBC_SEQ_OFF 2'h0
`define DBC_SEQ_B_TRACE 2'h1
`define DBC_SEQ_A_B 2'h2
`define DBC_SEQ_ALL 2'h3
`define DBC_IR_CAPTURE 8'h01
`define DBC_SEL_BASE 2'h0
`define DBC_SEL_MASK 2'h1
`define DBC_SEL_CNT 2'h2
`endif

/* File: dbc_pkg.sv */
// types shared by the debug control block
package dbc_pkg;
  typedef enum logic [3:0] {
    TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
    SH_DR = 4'h4, EX1_DR = 4'h5, PA_DR = 4'h6, EX2_DR = 4'h7,
    UPD_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'ha, SH_IR = 4'hb,
    EX1_IR = 4'hc, PA_IR = 4'hd, EX2_IR = 4'he, UPD_IR = 4'hf
  } dbc_tap_t;
  typedef struct packed {
    logic [13:0] rsvd;
    logic [1:0] sequence_select;
    logic debug_request_bit;
    logic internal_request_enable;
    logic trace_enable_bit;
    logic freeze_select;
    logic range_select_b;
    logic range_select_a;
    logic [4:0] access_qualifier_b;
    logic [4:0] access_qualifier_a;
  } dbc_ctrl_t;
  typedef struct packed {
    logic [31:0] base;
    logic [31:0] mask;
    logic [15:0] cnt;
    logic hit;
  } dbc_bp_state_t;
  typedef struct packed {
    logic tck_m, tck_s, tck_p, tms_m, tms_s, tdi_m, tdi_s;
    dbc_tap_t tap;
    logic [7:0] ir;
    logic [7:0] cmd;
    logic [31:0] dr;
    dbc_ctrl_t ctl;
    logic seq_a, seq_b, frz, hdro, dro, mbo, swo, tro, ack_p;
    logic dbg_req, brk_req, leave, trace_en, tdo, tdo_oe;
  } dbc_state_t;
endpackage : dbc_pkg

/* File: dbc_bp_if.sv */
// link between the control logic and one memory breakpoint unit
interface dbc_bp_if;
  logic [4:0] qual;
  logic range_sel, gate, wr_en;
  logic [1:0] wr_sel;
  logic [31:0] wr_data;
  logic acc_valid, acc_instr, acc_cof, acc_write, acc_super;
  logic [31:0] acc_addr;
  logic hit;
  logic [31:0] base, mask;
  logic [15:0] cnt;
  modport unit(input qual, range_sel, gate, wr_en, wr_sel, wr_data, acc_valid,
    acc_instr, acc_cof, acc_write, acc_super, acc_addr,
    output hit, base, mask, cnt);
  modport ctrl(output qual, range_sel, gate, wr_en, wr_sel, wr_data, acc_valid,
    acc_instr, acc_cof, acc_write, acc_super, acc_addr,
    input hit, base, mask, cnt);
endinterface : dbc_bp_if

/* File: dbc_bp_unit.sv */
// one memory breakpoint: address compare, qualifier and event counter
`include "dbc_params.svh"
module dbc_bp_unit import dbc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // control side
  dbc_bp_if.unit bp
);
  dbc_bp_state_t s_q, s_d;
  logic in_rng, ev;

  // reserved encodings fall through to zero
  function automatic logic qual_ok(input logic [4:0] q, input logic ins,
      input logic cof, input logic wr, input logic sup);
    logic priv, cls;
    priv = q[4] ? (q[3] == sup) : !q[3];
    case (q[2:0])
      3'h1: cls = 1'b1;
      3'h2: cls = ins;
      3'h3: cls = !ins;
      3'h4: cls = ins & cof;
      3'h5: cls = !ins & wr;
      3'h6: cls = !ins & !wr;
      default: cls = 1'b0;
    endcase
    return priv & cls;
  endfunction : qual_ok

  always_comb begin
    s_d = s_q;
    s_d.hit = 1'b0;
    in_rng = ((bp.acc_addr ^ s_q.base) & s_q.mask) == 32'h0000_0000;
    ev = bp.acc_valid & bp.gate & (in_rng ^ bp.range_sel) &
      qual_ok(bp.qual, bp.acc_instr, bp.acc_cof, bp.acc_write, bp.acc_super);
    // a counter write wins so stale events cannot leak into a new setup
    if (bp.wr_en) begin
      case (bp.wr_sel)
        `DBC_SEL_BASE: s_d.base = bp.wr_data;
        `DBC_SEL_MASK: s_d.mask = bp.wr_data;
        `DBC_SEL_CNT: s_d.cnt = bp.wr_data[15:0];
        default: s_d.cnt = s_q.cnt;
      endcase
    end else if (ev) begin
      if (s_q.cnt != 16'h0000) s_d.cnt = s_q.cnt - 16'h0001;
      else s_d.hit = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) s_q <= '0;
    else if (ce) s_q <= s_d;
  end

  assign bp.hit = s_q.hit;
  assign bp.base = s_q.base;
  assign bp.mask = s_q.mask;
  assign bp.cnt = s_q.cnt;

  a_hit_on_zero: assert property (@(posedge clk) disable iff (srst)
    ce && ev && !bp.wr_en && s_q.cnt == 16'h0000 |=> s_q.hit)
    else $error("zero counter event gave no hit");
  a_count_down: assert property (@(posedge clk) disable iff (srst)
    ce && ev && !bp.wr_en && s_q.cnt != 16'h0000 |=> !s_q.hit &&
    s_q.cnt == $past(s_q.cnt) - 16'h0001)
    else $error("counter did not step down");
  a_qual_off_quiet: assert property (@(posedge clk) disable iff (srst)
    ce && bp.qual == 5'h00 |=> !s_q.hit)
    else $error("disabled breakpoint hit");
endmodule : dbc_bp_unit

/* File: dbc_ctrl.sv */
// debug control register, serial test port and breakpoint sequencing
//
// Behaviour
// - sequence 00: breakpoints and trace independent
// - sequence 01: B hit arms trace, no request
// - sequence 10: A hit arms B, no request
// - sequence 11: no requests; trace after A then B
// - test logic reset clears sequence field
// - debug request bit forces debug entry
// - request bit keeps re-entering after exit
// - status shows processor mode field
// - enable bit gates internal hardware request
// - trace enable bit, cleared by test reset
// - freeze select: B hit freezes history instead
// - freeze holds until freeze flag cleared
// - range select: match inside or outside range
// - zero qualifier disables breakpoint
// - low qualifier bits choose access class
// - top qualifier bits choose privilege
// - test logic reset clears both qualifiers
// - status register: sixteen bits, read only
// - counter counts down, hit when zero
// - go with exit leaves debug mode
`include "dbc_params.svh"
module dbc_ctrl import dbc_pkg::*; (
  // clock, reset, enable
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // serial test port
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // processor handshake
  input wire logic dbg_ack,
  input wire logic [1:0] processor_mode_field,
  input wire logic sw_bkpt,
  input wire logic trace_zero,
  input wire logic internal_hw_request_in_n,
  // bus access attributes
  input wire logic acc_valid,
  input wire logic [31:0] acc_addr,
  input wire logic acc_instr,
  input wire logic acc_cof,
  input wire logic acc_write,
  input wire logic acc_super,
  // requests to the processor and trace logic
  output logic debug_req,
  output logic brk_req,
  output logic leave_debug,
  output logic pc_hist_freeze,
  output logic trace_count_en
);
  dbc_state_t s_q, s_d;
  logic rise, fall, hw_req, upd_wr;
  logic [4:0] rs;
  logic [15:0] stat;
  logic [31:0] rdv;

  dbc_bp_if bp_if[2] ();

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic dbc_tap_t tap_next(input dbc_tap_t t, input logic m);
    case (t)
      TLR: tap_next = m ? TLR : RTI;
      RTI: tap_next = m ? SEL_DR : RTI;
      SEL_DR: tap_next = m ? SEL_IR : CAP_DR;
      CAP_DR: tap_next = m ? EX1_DR : SH_DR;
      SH_DR: tap_next = m ? EX1_DR : SH_DR;
      EX1_DR: tap_next = m ? UPD_DR : PA_DR;
      PA_DR: tap_next = m ? EX2_DR : PA_DR;
      EX2_DR: tap_next = m ? UPD_DR : SH_DR;
      UPD_DR: tap_next = m ? SEL_DR : RTI;
      SEL_IR: tap_next = m ? TLR : CAP_IR;
      CAP_IR: tap_next = m ? EX1_IR : SH_IR;
      SH_IR: tap_next = m ? EX1_IR : SH_IR;
      EX1_IR: tap_next = m ? UPD_IR : PA_IR;
      PA_IR: tap_next = m ? EX2_IR : PA_IR;
      EX2_IR: tap_next = m ? UPD_IR : SH_IR;
      UPD_IR: tap_next = m ? SEL_DR : RTI;
      default: tap_next = TLR;
    endcase
  endfunction : tap_next

  // which breakpoint register a select code reaches: {hit, field}
  function automatic logic [2:0] bp_sel(input logic [4:0] r, input int u);
    logic [2:0] v;
    v = 3'h0;
    if (r == (u == 0 ? `DBC_RS_BASE_A : `DBC_RS_BASE_B)) v = {1'b1, `DBC_SEL_BASE};
    if (r == (u == 0 ? `DBC_RS_MASK_A : `DBC_RS_MASK_B)) v = {1'b1, `DBC_SEL_MASK};
    if (r == (u == 0 ? `DBC_RS_CNT_A : `DBC_RS_CNT_B)) v = {1'b1, `DBC_SEL_CNT};
    return v;
  endfunction : bp_sel

  assign rise = s_q.tck_s & ~s_q.tck_p;
  assign fall = ~s_q.tck_s & s_q.tck_p;
  assign rs = s_q.cmd[4:0];
  assign hw_req = s_q.ctl.internal_request_enable & ~internal_hw_request_in_n;
  assign upd_wr = rise & (s_q.tap == UPD_DR) & ~s_q.cmd[`DBC_CMD_RW];

  // status layout: zeros, hdro, dro, mbo, swo, to, freeze_flag, sqb, sqa, mode
  assign stat = {6'h00, s_q.hdro, s_q.dro, s_q.mbo, s_q.swo, s_q.tro,
    s_q.frz, s_q.seq_b, s_q.seq_a, processor_mode_field};

  // ************************************************************
  // breakpoint units
  // ************************************************************
  for (genvar i = 0; i < 2; i++) begin : g_bp
    logic [2:0] sel;
    assign sel = bp_sel(rs, i);
    assign bp_if[i].qual = i == 0 ? s_q.ctl.access_qualifier_a :
      s_q.ctl.access_qualifier_b;
    assign bp_if[i].range_sel = i == 0 ? s_q.ctl.range_select_a :
      s_q.ctl.range_select_b;
    // in sequences 10 and 11, breakpoint b stays suspended until a arms it
    assign bp_if[i].gate = i == 0 ? 1'b1 : (~s_q.ctl.sequence_select[1] | s_q.seq_a);
    assign bp_if[i].wr_en = upd_wr & sel[2];
    assign bp_if[i].wr_sel = sel[1:0];
    assign bp_if[i].wr_data = s_q.dr;
    assign bp_if[i].acc_valid = acc_valid;
    assign bp_if[i].acc_addr = acc_addr;
    assign bp_if[i].acc_instr = acc_instr;
    assign bp_if[i].acc_cof = acc_cof;
    assign bp_if[i].acc_write = acc_write;
    assign bp_if[i].acc_super = acc_super;
    dbc_bp_unit u_bp (
      .clk(clk),
      .srst(srst),
      .ce(ce),
      .bp(bp_if[i])
    );
  end

  // ************************************************************
  // read data for a capture
  // ************************************************************
  always_comb begin
    rdv = 32'h0000_0000;
    case (rs)
      `DBC_RS_CTRL: rdv = s_q.ctl;
      `DBC_RS_STAT: rdv = {16'h0000, stat};
      `DBC_RS_BASE_A: rdv = bp_if[0].base;
      `DBC_RS_BASE_B: rdv = bp_if[1].base;
      `DBC_RS_MASK_A: rdv = bp_if[0].mask;
      `DBC_RS_MASK_B: rdv = bp_if[1].mask;
      `DBC_RS_CNT_A: rdv = {16'h0000, bp_if[0].cnt};
      `DBC_RS_CNT_B: rdv = {16'h0000, bp_if[1].cnt};
      default: rdv = 32'h0000_0000;
    endcase
  end

  // ************************************************************
  // control state
  // ************************************************************
  always_comb begin
    logic a_req, b_req;
    a_req = 1'b0;
    b_req = 1'b0;
    s_d = s_q;
    // pins come from outside this clock: two flops before use
    s_d.tck_m = tck;
    s_d.tck_s = s_q.tck_m;
    s_d.tck_p = s_q.tck_s;
    s_d.tms_m = tms;
    s_d.tms_s = s_q.tms_m;
    s_d.tdi_m = tdi;
    s_d.tdi_s = s_q.tdi_m;
    s_d.leave = 1'b0;
    s_d.ack_p = dbg_ack;

    if (rise) begin
      s_d.tap = tap_next(s_q.tap, s_q.tms_s);
      case (s_q.tap)
        CAP_IR: s_d.ir = `DBC_IR_CAPTURE;
        SH_IR: s_d.ir = {s_q.tdi_s, s_q.ir[7:1]};
        UPD_IR: s_d.cmd = s_q.ir;
        CAP_DR: s_d.dr = rdv;
        SH_DR: s_d.dr = {s_q.tdi_s, s_q.dr[31:1]};
        UPD_DR: begin
          if (!s_q.cmd[`DBC_CMD_RW] && rs == `DBC_RS_CTRL) s_d.ctl = s_q.dr;
          if (s_q.cmd[`DBC_CMD_GO] && s_q.cmd[`DBC_CMD_EX] &&
              (rs == `DBC_RS_CPUSCR || rs == `DBC_RS_NONE)) begin
            s_d.leave = 1'b1;
            {s_d.hdro, s_d.dro, s_d.mbo, s_d.swo, s_d.tro} = 5'h00;
            {s_d.frz, s_d.seq_a, s_d.seq_b} = 3'h0;
          end
        end
        default: s_d.ir = s_q.ir;
      endcase
    end
    // tdo moves on the falling edge so the host samples it stable
    if (fall) begin
      s_d.tdo = s_q.tap == SH_DR ? s_q.dr[0] : s_q.ir[0];
      s_d.tdo_oe = s_q.tap == SH_DR || s_q.tap == SH_IR;
    end

    // events are applied after the exit clears so a set wins there; the test logic reset clear comes last and wins
    if (bp_if[0].hit) begin
      if (s_q.ctl.sequence_select[1]) s_d.seq_a = 1'b1;
      else a_req = 1'b1;
    end
    if (bp_if[1].hit) begin
      if (s_q.ctl.sequence_select[0]) s_d.seq_b = 1'b1;
      else b_req = 1'b1;
    end
    if (b_req && s_q.ctl.freeze_select) begin
      b_req = 1'b0;
      s_d.frz = 1'b1;
    end
    if (a_req || b_req) s_d.brk_req = 1'b1;
    else if (dbg_ack) s_d.brk_req = 1'b0;
    // level request: while the bit is set, any exit is followed by re-entry
    s_d.dbg_req = s_q.ctl.debug_request_bit | hw_req;
    s_d.trace_en = s_q.ctl.trace_enable_bit &
      (~s_q.ctl.sequence_select[0] | s_q.seq_b);

    // occurrence flags latch on the rising acknowledge
    if (dbg_ack && !s_q.ack_p) begin
      if (s_q.ctl.debug_request_bit) s_d.dro = 1'b1;
      if (hw_req) s_d.hdro = 1'b1;
      if (s_q.brk_req) s_d.mbo = 1'b1;
      if (sw_bkpt) s_d.swo = 1'b1;
      if (trace_zero && s_q.ctl.trace_enable_bit) s_d.tro = 1'b1;
    end

    if (s_q.tap == TLR) begin
      s_d.ctl = `DBC_CTL_RESET;
      {s_d.hdro, s_d.dro, s_d.mbo, s_d.swo, s_d.tro} = 5'h00;
      {s_d.frz, s_d.seq_a, s_d.seq_b} = 3'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) s_q <= '0;
    else if (ce) s_q <= s_d;
  end

  assign tdo = s_q.tdo;
  assign tdo_oe = s_q.tdo_oe;
  assign debug_req = s_q.dbg_req;
  assign brk_req = s_q.brk_req;
  assign leave_debug = s_q.leave;
  assign pc_hist_freeze = s_q.frz;
  assign trace_count_en = s_q.trace_en;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_dr_forces_req: assert property (ce && s_q.ctl.debug_request_bit |=> debug_req)
    else $error("request bit set but no debug request");
  a_dr_after_exit: assert property (
    ce && leave_debug && s_q.ctl.debug_request_bit |-> debug_req)
    else $error("exit cleared a forced request");
  a_idr_gated: assert property (
    ce && !s_q.ctl.internal_request_enable && !s_q.ctl.debug_request_bit
    |=> !debug_req)
    else $error("internal request passed while disabled");
  a_seq_off_brk: assert property (
    ce && s_q.ctl.sequence_select == `DBC_SEQ_OFF && bp_if[1].hit &&
    !s_q.ctl.freeze_select |=> brk_req)
    else $error("independent b hit gave no request");
  a_seq_b_trace: assert property (
    ce && s_q.ctl.sequence_select == `DBC_SEQ_B_TRACE && bp_if[1].hit &&
    !bp_if[0].hit && !brk_req |=> !brk_req && s_q.seq_b)
    else $error("b hit in trace sequence misbehaved");
  a_seq_a_b: assert property (
    ce && s_q.ctl.sequence_select == `DBC_SEQ_A_B && bp_if[0].hit &&
    !bp_if[1].hit && !brk_req |=> !brk_req && s_q.seq_a)
    else $error("a hit in chained sequence misbehaved");
  a_seq_all_trace: assert property (
    ce && s_q.ctl.sequence_select == `DBC_SEQ_ALL && !s_q.seq_b &&
    !bp_if[1].hit |=> !trace_count_en)
    else $error("trace ran before a then b");
  a_tlr_clears: assert property (
    ce && s_q.tap == TLR |=> s_q.ctl == `DBC_CTL_RESET)
    else $error("test reset left control bits");
  a_freeze_sel: assert property (
    ce && bp_if[1].hit && s_q.ctl.sequence_select == `DBC_SEQ_OFF &&
    s_q.ctl.freeze_select && !bp_if[0].hit && !brk_req |=> pc_hist_freeze && !brk_req)
    else $error("freeze select did not freeze");
  a_freeze_hold: assert property (
    $fell(pc_hist_freeze) |-> leave_debug || $past(s_q.tap) == TLR)
    else $error("freeze dropped without flag clear");
endmodule : dbc_ctrl

/* File: dbc_cpu_model.sv */
// processor-side partner: debug acknowledge and mode reporting
module dbc_cpu_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // requests from the debug block
  input wire logic debug_req,
  input wire logic brk_req,
  input wire logic leave_debug,
  input wire logic ack_slow,
  // answer to the debug block
  output logic dbg_ack,
  output logic [1:0] processor_mode_field
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  // a slow core finishes its current instruction before it acknowledges
  always_ff @(posedge clk) begin
    if (srst || leave_debug) begin
      dbg_ack <= 1'b0;
      processor_mode_field <= 2'h0;
      wait_q <= 4'h0;
    end else if ((debug_req || brk_req) && !dbg_ack) begin
      wait_q <= wait_q + 4'h1;
      if (wait_q >= (ack_slow ? 4'h6 : 4'h1)) begin
        dbg_ack <= 1'b1;
        processor_mode_field <= 2'h2;
        wait_q <= 4'h0;
      end
    end
  end
endmodule : dbc_cpu_model

/* File: dbc_ctrl_tb.sv */
// self-checking bench for the debug control block
`include "dbc_params.svh"
module dbc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(nm, x, y) begin n_checks++; if ((y) !== (x)) begin error_cnt++; \
    $display("mismatch %s exp %0h got %0h", nm, x, y); end end
  logic clk = 1'b0, srst = 1'b1, ce = 1'b1, tck = 1'b0, tms = 1'b1, tdi = 1'b0;
  logic hw_n = 1'b1, slow = 1'b0, acc_valid = 1'b0, acc_instr = 1'b0, acc_cof = 1'b0;
  logic acc_write = 1'b0, acc_super = 1'b0;
  logic [31:0] acc_addr = 32'h0, rd;
  logic tdo, tdo_oe, dbg_ack, debug_req, brk_req, leave_debug, pc_hist_freeze, trace_count_en;
  logic [1:0] pmode;
  logic [3:0] kinds [6] = '{4'b1000, 4'b1101, 4'b0010, 4'b0001, 4'b1100, 4'b0011};
  int error_cnt = 0, n_checks = 0, n_leave = 0;
  dbc_ctrl uut (.clk(clk), .srst(srst), .ce(ce), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .dbg_ack(dbg_ack), .processor_mode_field(pmode), .sw_bkpt(1'b0),
    .trace_zero(1'b0), .internal_hw_request_in_n(hw_n), .acc_valid(acc_valid),
    .acc_addr(acc_addr), .acc_instr(acc_instr), .acc_cof(acc_cof), .acc_write(acc_write),
    .acc_super(acc_super), .debug_req(debug_req), .brk_req(brk_req),
    .leave_debug(leave_debug), .pc_hist_freeze(pc_hist_freeze),
    .trace_count_en(trace_count_en));
  dbc_cpu_model cpu (.clk(clk), .srst(srst), .debug_req(debug_req), .brk_req(brk_req),
    .leave_debug(leave_debug), .ack_slow(slow), .dbg_ack(dbg_ack),
    .processor_mode_field(pmode));
  initial begin
    forever #2 clk = ~clk;
  end
  always @(negedge clk) begin
    if (leave_debug === 1'b1) n_leave++;
  end
  // ****************
  // tasks
  // ****************
  task automatic clks(input int n);
    repeat (n) @(negedge clk);
  endtask : clks
  // one test clock period of 16 clk, tdo sampled late in the low phase
  task automatic tcyc(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    tck = 1'b0;
    clks(8);
    o = tdo;
    tck = 1'b1;
    clks(8);
  endtask : tcyc
  // from run-test/idle: sel=1 data scan, sel=2 instruction scan
  task automatic scan(input int sel, input int n, input logic [31:0] din,
      output logic [31:0] dout);
    logic o;
    dout = 32'h0;
    tcyc(1'b0, 1'b0, o);
    repeat (sel) tcyc(1'b1, 1'b0, o);
    repeat (2) tcyc(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      tcyc(i == n - 1, din[i], o);
      dout[i] = o;
      if (sel == 1 && i == 0) `CHK("oe shift", 1'b1, tdo_oe);
    end
    tcyc(1'b1, 1'b0, o);
    tcyc(1'b0, 1'b0, o);
  endtask : scan
  task automatic reg_op(input logic [7:0] cmd, input logic [31:0] din);
    logic [31:0] junk;
    scan(2, 8, {24'h0, cmd}, junk);
    scan(1, 32, din, rd);
  endtask : reg_op
  task automatic wr(input logic [4:0] rs, input logic [31:0] d);
    reg_op({3'b000, rs}, d);
  endtask : wr
  task automatic rdr(input logic [4:0] rs);
    reg_op({3'b100, rs}, 32'h0);
  endtask : rdr
  task automatic go_exit;
    reg_op({3'b011, `DBC_RS_NONE}, 32'h0);
    clks(20);
  endtask : go_exit
  task automatic rst;
    srst = 1'b1;
    // park the test clock low so no false edge follows the release
    tck = 1'b0;
    clks(4);
    srst = 1'b0;
  endtask : rst
  // k = instruction, change of flow, write, supervisor
  task automatic acc(input logic [31:0] a, input logic [3:0] k);
    acc_addr = a;
    {acc_instr, acc_cof, acc_write, acc_super} = k;
    acc_valid = 1'b1;
    clks(1);
    acc_valid = 1'b0;
    clks(2);
  endtask : acc
  // two windows: A at 0x100, B at 0x200, every address bit compared
  task automatic seq_setup(input logic [31:0] ctl);
    rst();
    wr(`DBC_RS_BASE_A, 32'h0000_0100);
    wr(`DBC_RS_MASK_A, 32'hffff_ffff);
    wr(`DBC_RS_BASE_B, 32'h0000_0200);
    wr(`DBC_RS_MASK_B, 32'hffff_ffff);
    wr(`DBC_RS_CTRL, ctl);
  endtask : seq_setup
  function automatic logic hit_exp(input logic [4:0] q, input logic [3:0] k);
    logic i, c, w, s, p;
    {i, c, w, s} = k;
    p = (q[4:3] == 2'b00) || (q[4:3] == {1'b1, s});
    case (q[2:0])
      3'h1: return p;
      3'h2: return p && i;
      3'h3: return p && !i;
      3'h4: return p && i && c;
      3'h5: return p && !i && w;
      3'h6: return p && !i && !w;
      default: return 1'b0;
    endcase
  endfunction : hit_exp
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  // ****************
  // tests
  // ****************
  initial begin
    #400000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    logic e, o;
    clks(4);
    srst = 1'b0;
    rdr(`DBC_RS_CTRL);
    `CHK("ctrl reset", 32'h0, rd);
    wr(`DBC_RS_CTRL, 32'hfffc_7fff);
    rdr(`DBC_RS_CTRL);
    `CHK("ctrl rw", 32'hfffc_7fff, rd);
    `CHK("trace free", 1'b1, trace_count_en);
    repeat (5) tcyc(1'b1, 1'b0, o);
    rdr(`DBC_RS_CTRL);
    `CHK("ctrl tlr", 32'h0, rd);
    rst();
    slow = 1'b1;
    wr(`DBC_RS_CTRL, 32'h0000_8000);
    `CHK("dbg req", 1'b1, debug_req);
    clks(10);
    rdr(`DBC_RS_STAT);
    `CHK("status", 32'h0000_0102, rd);
    `CHK("oe idle", 1'b0, tdo_oe);
    go_exit();
    `CHK("leave", 1, n_leave);
    `CHK("reenter", 1'b1, dbg_ack);
    wr(`DBC_RS_CTRL, 32'h0);
    `CHK("dbg req off", 1'b0, debug_req);
    go_exit();
    `CHK("resumed", 1'b0, dbg_ack);
    slow = 1'b0;
    rst();
    hw_n = 1'b0;
    clks(3);
    `CHK("hw gated", 1'b0, debug_req);
    wr(`DBC_RS_CTRL, 32'h0000_4000);
    `CHK("hw on", 1'b1, debug_req);
    hw_n = 1'b1;
    clks(3);
    `CHK("hw off", 1'b0, debug_req);
    for (int q = 0; q < 32; q++) begin
      rst();
      wr(`DBC_RS_CTRL, {27'h0, q[4:0]});
      for (int j = 0; j < 6; j++) begin
        e = hit_exp(q[4:0], kinds[j]);
        acc(32'h0, kinds[j]);
        `CHK("qual", e, brk_req);
        if (e) break;
      end
    end
    seq_setup(32'h0000_0401);
    acc(32'h0000_0100, 4'h0);
    `CHK("inside", 1'b0, brk_req);
    acc(32'h0000_0200, 4'h0);
    `CHK("outside", 1'b1, brk_req);
    rst();
    wr(`DBC_RS_CNT_A, 32'h2);
    wr(`DBC_RS_CTRL, 32'h1);
    for (int n = 0; n < 3; n++) begin
      acc(32'h0, 4'h0);
      `CHK("count", n == 2, brk_req);
    end
    rst();
    wr(`DBC_RS_CTRL, 32'h0000_1020);
    for (int n = 0; n < 2; n++) begin
      acc(32'h0, 4'h0);
      `CHK("frz brk", 1'b0, brk_req);
      `CHK("frozen", 1'b1, pc_hist_freeze);
    end
    go_exit();
    `CHK("thawed", 1'b0, pc_hist_freeze);
    seq_setup(32'h0002_0021);
    acc(32'h0000_0200, 4'h0);
    `CHK("b held", 1'b0, brk_req);
    acc(32'h0000_0100, 4'h0);
    `CHK("a silent", 1'b0, brk_req);
    acc(32'h0000_0200, 4'h0);
    `CHK("b armed", 1'b1, brk_req);
    seq_setup(32'h0001_2021);
    `CHK("tr held", 1'b0, trace_count_en);
    acc(32'h0000_0200, 4'h0);
    clks(2);
    `CHK("b silent", 1'b0, brk_req);
    `CHK("tr on", 1'b1, trace_count_en);
    seq_setup(32'h0003_2021);
    acc(32'h0000_0200, 4'h0);
    acc(32'h0000_0100, 4'h0);
    clks(2);
    `CHK("tr wait", 1'b0, trace_count_en);
    acc(32'h0000_0200, 4'h0);
    clks(2);
    `CHK("no req", 1'b0, brk_req);
    `CHK("tr a b", 1'b1, trace_count_en);
    seq_setup(32'h0000_2021);
    acc(32'h0000_0100, 4'h0);
    `CHK("a free", 1'b1, brk_req);
    go_exit();
    acc(32'h0000_0200, 4'h0);
    `CHK("b free", 1'b1, brk_req);
    print_verdict();
  end
endmodule : dbc_ctrl_tb
